// ### pkg/sma_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SMA_MAP_SVH
`define SMA_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SMA_REG_CTRL 8'h00
`define SMA_REG_TREB_CORNER 8'h04
`define SMA_REG_LEFT_TREB 8'h08
`define SMA_REG_RIGHT_TREB 8'h0C
`define SMA_REG_BASS_CORNER 8'h10
`define SMA_REG_XFEED 8'h14
`define SMA_REG_STEREO_DLY 8'h18
`define SMA_REG_LEFT_DLY 8'h1C
`define SMA_REG_RIGHT_DLY 8'h20
`define SMA_REG_LEFT_FINE 8'h24
`define SMA_REG_RIGHT_FINE 8'h28
`define SMA_REG_FEEDBACK 8'h2C
`define SMA_REG_LEFT_DC 8'h30
`define SMA_REG_RIGHT_DC 8'h34
`define SMA_REG_BINAURAL_BOOST_SETTING 8'h38
`define SMA_REG_LEFT_FTIME 8'h3C
`define SMA_REG_RIGHT_FTIME 8'h40
`define SMA_REG_STATUS 8'h44
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMA_CTRL_RATE_LSB 0
`define SMA_CTRL_DC_LSB 2
// ----------------------------------------
// reset values and setting limits
// ----------------------------------------
`define SMA_RST_GAIN 16'h4000
`define SMA_RST_COEF 16'h0800
`define SMA_XF_LIMIT 16'sh4000
`define SMA_BINAURAL_BOOST_SETTING_MAX 4'hA
// ----------------------------------------
// timing and scaling
// ----------------------------------------
`define SMA_STEP_MS 10
`define SMA_MAX_MS 5000
`define SMA_STEP_SMP_48 (48000 * `SMA_STEP_MS / 1000)
`define SMA_STEP_SMP_44 (44100 * `SMA_STEP_MS / 1000)
`define SMA_STEP_SMP_32 (32000 * `SMA_STEP_MS / 1000)
`define SMA_COARSE_MAX (`SMA_MAX_MS / `SMA_STEP_MS * `SMA_STEP_SMP_48)
`define SMA_COARSE_DEPTH (`SMA_COARSE_MAX + 1)
`define SMA_FINE_DEPTH 512
`define SMA_T48_US_X1000 20833
`define SMA_T44_US_X1000 22676
`define SMA_T32_US_X1000 31250
`define SMA_DC_SHIFT 12
`define SMA_BINAURAL_BOOST_SETTING_K_STEP 214
`define SMA_BINAURAL_BOOST_SETTING_BOOST_SHIFT 3
`define SMA_PCT_Q16 655
`define SMA_PCT_TO_FS 83886
`endif

// ### pkg/sma_pkg.sv
// types shared by the stereo mastering adjust block
package sma_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DC, ST_EQ, ST_XF, ST_BINAURAL_BOOST_SETTING, ST_CRS, ST_FIN, ST_OUT
  } sma_state_type;
  typedef enum logic [1:0] {DC_RESET, DC_MANUAL, DC_AUTO} sma_dc_mode_type;
endpackage

// ### rtl/sma_stereo_adjust.sv
// stereo mastering adjust datapath with avalon-mm register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`include "sma_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sma_stereo_adjust (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // audio input frame
  input wire logic i_sample_valid,
  input wire logic signed [23:0] i_left_sample,
  input wire logic signed [23:0] i_right_sample,
  // audio output frame
  output logic o_sample_valid,
  output logic signed [23:0] o_left_sample,
  output logic signed [23:0] o_right_sample,
  output logic o_busy
);
  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic logic signed [49:0] ext(input logic signed [23:0] v);
    ext = {{26{v[23]}}, v};
  endfunction
  function automatic logic signed [23:0] sat(input logic signed [49:0] v);
    if (v > 50'sh7FFFFF) begin
      sat = 24'sh7FFFFF;
    end else if (v < -50'sh800000) begin
      sat = 24'sh800000;
    end else begin
      sat = v[23:0];
    end
  endfunction
  function automatic logic signed [49:0] mulq(input logic signed [49:0] v,
                                              input logic signed [17:0] k,
                                              input int sh);
    mulq = (v * $signed({{32{k[17]}}, k})) >>> sh;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0] rate_sel;
  logic [1:0] dc_null_mode;
  logic [15:0] independent_treble_corner;
  logic [15:0] left_treble_gain;
  logic [15:0] right_treble_gain;
  logic [15:0] bass_corner;
  logic signed [15:0] spatial_crossfeed_amount;
  logic [8:0] stereo_coarse_delay;
  logic [8:0] left_coarse_delay;
  logic [8:0] right_coarse_delay;
  logic [8:0] left_fine_delay;
  logic [8:0] right_fine_delay;
  logic [31:0] feedback_gains;
  logic [3:0] binaural_boost_setting;
  logic ack;
  logic [31:0] rd_mux;
  sma_pkg::sma_state_type state;
  logic [17:0] wr_ptr;
  logic [8:0] fine_ptr;
  logic [17:0] fill;
  logic signed [25:0] diff_lp;
  logic signed [23:0] binaural_boost_setting_l;
  logic signed [23:0] binaural_boost_setting_r;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req = i_avs_read | i_avs_write;
  wire wr_en = i_avs_write & ack;
  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wr_val = (rd_mux & ~be_mask) | (i_avs_writedata & be_mask);
  wire sel_ctrl = i_avs_address == `SMA_REG_CTRL;
  wire sel_tcorner = i_avs_address == `SMA_REG_TREB_CORNER;
  wire sel_ltreb = i_avs_address == `SMA_REG_LEFT_TREB;
  wire sel_rtreb = i_avs_address == `SMA_REG_RIGHT_TREB;
  wire sel_bcorner = i_avs_address == `SMA_REG_BASS_CORNER;
  wire sel_xfeed = i_avs_address == `SMA_REG_XFEED;
  wire sel_sdly = i_avs_address == `SMA_REG_STEREO_DLY;
  wire sel_left_coarse_delay = i_avs_address == `SMA_REG_LEFT_DLY;
  wire sel_right_coarse_delay = i_avs_address == `SMA_REG_RIGHT_DLY;
  wire sel_lfine = i_avs_address == `SMA_REG_LEFT_FINE;
  wire sel_rfine = i_avs_address == `SMA_REG_RIGHT_FINE;
  wire sel_fb = i_avs_address == `SMA_REG_FEEDBACK;
  wire sel_binaural_boost_setting = i_avs_address == `SMA_REG_BINAURAL_BOOST_SETTING;
  wire [1:0] dc_wr = {wr_en & (i_avs_address == `SMA_REG_RIGHT_DC),
                      wr_en & (i_avs_address == `SMA_REG_LEFT_DC)};
  // manual offset in percent scaled to full-scale units
  wire signed [23:0] dc_wr_val = 24'($signed(wr_val[7:0]) * 25'sd`SMA_PCT_TO_FS);

  assign o_avs_waitrequest = req & ~ack;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (i_avs_read & ~ack) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_sel <= 2'h0;
      dc_null_mode <= 2'h0;
      independent_treble_corner <= `SMA_RST_COEF;
      left_treble_gain <= `SMA_RST_GAIN;
      right_treble_gain <= `SMA_RST_GAIN;
      bass_corner <= `SMA_RST_COEF;
      spatial_crossfeed_amount <= 16'sh0000;
      stereo_coarse_delay <= 9'h000;
      left_coarse_delay <= 9'h000;
      right_coarse_delay <= 9'h000;
      left_fine_delay <= 9'h000;
      right_fine_delay <= 9'h000;
      feedback_gains <= 32'h00000000;
      binaural_boost_setting <= 4'h0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        rate_sel <= wr_val[`SMA_CTRL_RATE_LSB +: 2];
        dc_null_mode <= wr_val[`SMA_CTRL_DC_LSB +: 2];
      end else if (sel_tcorner) begin
        independent_treble_corner <= wr_val[15:0];
      end else if (sel_ltreb) begin
        left_treble_gain <= wr_val[15:0];
      end else if (sel_rtreb) begin
        right_treble_gain <= wr_val[15:0];
      end else if (sel_bcorner) begin
        bass_corner <= wr_val[15:0];
      end else if (sel_xfeed) begin
        spatial_crossfeed_amount <= wr_val[15:0];
      end else if (sel_sdly) begin
        stereo_coarse_delay <= wr_val[8:0];
      end else if (sel_left_coarse_delay) begin
        left_coarse_delay <= wr_val[8:0];
      end else if (sel_right_coarse_delay) begin
        right_coarse_delay <= wr_val[8:0];
      end else if (sel_lfine) begin
        left_fine_delay <= wr_val[8:0];
      end else if (sel_rfine) begin
        right_fine_delay <= wr_val[8:0];
      end else if (sel_fb) begin
        feedback_gains <= wr_val;
      end else if (sel_binaural_boost_setting) begin
        binaural_boost_setting <= wr_val[3:0];
      end
    end
  end

  // ----------------------------------------
  // rate dependent scaling
  // ----------------------------------------
  wire [8:0] step_smp = (rate_sel == 2'h1) ? 9'(`SMA_STEP_SMP_44) :
                        (rate_sel == 2'h2) ? 9'(`SMA_STEP_SMP_32) : 9'(`SMA_STEP_SMP_48);
  wire [14:0] smp_ns = (rate_sel == 2'h1) ? 15'(`SMA_T44_US_X1000) :
                       (rate_sel == 2'h2) ? 15'(`SMA_T32_US_X1000) :
                       15'(`SMA_T48_US_X1000);
  wire signed [15:0] xf_amt = (spatial_crossfeed_amount > `SMA_XF_LIMIT) ? `SMA_XF_LIMIT :
                              (spatial_crossfeed_amount < -`SMA_XF_LIMIT) ? -`SMA_XF_LIMIT :
                              spatial_crossfeed_amount;
  wire [3:0] binaural_boost_setting_set = (binaural_boost_setting > `SMA_BINAURAL_BOOST_SETTING_MAX) ? `SMA_BINAURAL_BOOST_SETTING_MAX :
                        binaural_boost_setting;
  wire [8:0] coarse_steps [0:1];
  wire [8:0] fine_dly [0:1];
  wire [15:0] treb_gain [0:1];
  assign coarse_steps[0] = left_coarse_delay;
  assign coarse_steps[1] = right_coarse_delay;
  assign fine_dly[0] = left_fine_delay;
  assign fine_dly[1] = right_fine_delay;
  assign treb_gain[0] = left_treble_gain;
  assign treb_gain[1] = right_treble_gain;
  wire st_go = (state == sma_pkg::ST_OUT);

  // ----------------------------------------
  // per-channel datapath
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [23:0] v;
    logic signed [23:0] t_lp;
    logic signed [23:0] b_lp;
    logic signed [23:0] ctap;
    logic signed [23:0] fout;
    logic signed [23:0] dc_est;
    logic signed [23:0] corr;
    logic signed [23:0] cmem [0:`SMA_COARSE_DEPTH-1];
    logic signed [23:0] fmem [0:`SMA_FINE_DEPTH-1];
    wire signed [23:0] in_smp = (c == 0) ? i_left_sample : i_right_sample;
    // estimate tracks the raw input, not the corrected signal
    wire signed [23:0] next_dc_est = sat(ext(dc_est) +
                                     ((ext(in_smp) - ext(dc_est)) >>> `SMA_DC_SHIFT));
    wire signed [23:0] dc_apply = (dc_null_mode == sma_pkg::DC_RESET) ? 24'sh000000 : corr;
    wire signed [23:0] next_t_lp = sat(ext(t_lp) + mulq(ext(v) - ext(t_lp),
                                   {2'b00, independent_treble_corner}, 16));
    // low-pass output plus scaled high part: zero gain leaves the plain low-pass output
    wire signed [23:0] treb_out = sat(ext(next_t_lp) + mulq(ext(v) - ext(next_t_lp),
                                  {2'b00, treb_gain[c]}, 14));
    wire signed [23:0] next_b_lp = sat(ext(b_lp) + mulq(ext(v) - ext(b_lp),
                                   {2'b00, bass_corner}, 16));
    wire signed [23:0] xf_out = sat(ext(v) - mulq(ext(g_ch[1-c].next_b_lp),
                                {{2{xf_amt[15]}}, xf_amt}, 14));
    wire [9:0] steps = 10'(stereo_coarse_delay) + 10'(coarse_steps[c]);
    wire [18:0] cd_raw = 19'(steps * step_smp);
    // is the controller's; clamp keeps the read pointer inside the line
    wire [17:0] cdly = (cd_raw > 19'(`SMA_COARSE_MAX)) ? 18'(`SMA_COARSE_MAX) : cd_raw[17:0];
    wire [18:0] crd_wrap = 19'(wr_ptr) + 19'(`SMA_COARSE_DEPTH) - 19'(cdly);
    wire [17:0] crd = (wr_ptr >= cdly) ? (wr_ptr - cdly) : crd_wrap[17:0];
    wire [8:0] frd = fine_ptr - fine_dly[c];
    wire [7:0] fbo_pct = feedback_gains[16*c +: 8];
    wire [7:0] fbf_pct = feedback_gains[16*c+8 +: 8];
    wire signed [17:0] fbo_k = {{10{fbo_pct[7]}}, fbo_pct} * 18'sh0028F;
    wire signed [17:0] fbf_k = {{10{fbf_pct[7]}}, fbf_pct} * 18'sh0028F;
    wire signed [23:0] cw = sat(ext(v) + mulq(ext(fout), fbo_k, 16));
    wire signed [23:0] fw = sat(ext(ctap) + mulq(ext(fout), fbf_k, 16));
    wire signed [31:0] corr_pct = (32'(corr) * 32'sh00000064) >>> 23;
    wire signed [23:0] next_ctap = (cdly == 18'h00000) ? cw :
                                   (fill < cdly) ? 24'sh000000 : cmem[crd];
    wire signed [23:0] next_fout = (fine_dly[c] == 9'h000) ? fw :
                                   (fill < 18'(fine_dly[c])) ? 24'sh000000 : fmem[frd];

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        dc_est <= 24'sh000000;
        corr <= 24'sh000000;
      end else if (dc_wr[c]) begin
        corr <= dc_wr_val;
      end else if (state == sma_pkg::ST_IDLE && i_sample_valid) begin
        dc_est <= next_dc_est;
        if (dc_null_mode == sma_pkg::DC_AUTO) begin
          corr <= next_dc_est;
        end
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        v <= 24'sh000000;
        t_lp <= 24'sh000000;
        b_lp <= 24'sh000000;
        ctap <= 24'sh000000;
        fout <= 24'sh000000;
      end else begin
        case (state)
          sma_pkg::ST_IDLE: begin
            if (i_sample_valid) begin
              v <= in_smp;
            end
          end
          sma_pkg::ST_DC: v <= sat(ext(v) - ext(dc_apply));
          sma_pkg::ST_EQ: begin
            t_lp <= next_t_lp;
            v <= treb_out;
          end
          sma_pkg::ST_XF: begin
            b_lp <= next_b_lp;
            v <= xf_out;
          end
          sma_pkg::ST_BINAURAL_BOOST_SETTING: v <= (c == 0) ? binaural_boost_setting_l : binaural_boost_setting_r;
          sma_pkg::ST_CRS: ctap <= next_ctap;
          sma_pkg::ST_FIN: fout <= next_fout;
          default: v <= v;
        endcase
      end
    end

    // delay memories hold no reset; unfilled taps read as silence
    always_ff @(posedge i_sys_clk) begin
      if (state == sma_pkg::ST_CRS) begin
        cmem[wr_ptr] <= cw;
      end
      if (state == sma_pkg::ST_FIN) begin
        fmem[fine_ptr] <= fw;
      end
    end
  end

  // ----------------------------------------
  // binaural shuffler
  // ----------------------------------------
  wire signed [49:0] mat_sum = ext(g_ch[0].v) + ext(g_ch[1].v);
  wire signed [49:0] mat_diff = ext(g_ch[0].v) - ext(g_ch[1].v);
  wire [17:0] binaural_boost_setting_k = 18'(binaural_boost_setting_set * 16'(`SMA_BINAURAL_BOOST_SETTING_K_STEP));
  wire signed [49:0] diff_lp_ext = {{24{diff_lp[25]}}, diff_lp};
  wire signed [49:0] next_diff_lp = diff_lp_ext + mulq(mat_diff - diff_lp_ext, binaural_boost_setting_k, 16);
  // adding eight times the low-passed difference gives nine times, about 19 dB, at dc
  wire signed [49:0] diff_boost = (binaural_boost_setting_set == 4'h0) ? mat_diff :
                                  mat_diff + (next_diff_lp <<< `SMA_BINAURAL_BOOST_SETTING_BOOST_SHIFT);
  assign binaural_boost_setting_l = sat((mat_sum + diff_boost) >>> 1);
  assign binaural_boost_setting_r = sat((mat_sum - diff_boost) >>> 1);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      diff_lp <= 26'sh0000000;
    end else if (state == sma_pkg::ST_BINAURAL_BOOST_SETTING) begin
      diff_lp <= (binaural_boost_setting_set == 4'h0) ? 26'sh0000000 : next_diff_lp[25:0];
    end
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  assign o_busy = (state != sma_pkg::ST_IDLE);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= sma_pkg::ST_IDLE;
      wr_ptr <= 18'h00000;
      fine_ptr <= 9'h000;
      fill <= 18'h00000;
      o_sample_valid <= 1'b0;
      o_left_sample <= 24'sh000000;
      o_right_sample <= 24'sh000000;
    end else begin
      o_sample_valid <= 1'b0;
      case (state)
        sma_pkg::ST_IDLE: begin
          if (i_sample_valid) begin
            state <= sma_pkg::ST_DC;
          end
        end
        sma_pkg::ST_DC: state <= sma_pkg::ST_EQ;
        sma_pkg::ST_EQ: state <= sma_pkg::ST_XF;
        sma_pkg::ST_XF: state <= sma_pkg::ST_BINAURAL_BOOST_SETTING;
        sma_pkg::ST_BINAURAL_BOOST_SETTING: state <= sma_pkg::ST_CRS;
        sma_pkg::ST_CRS: state <= sma_pkg::ST_FIN;
        sma_pkg::ST_FIN: state <= sma_pkg::ST_OUT;
        default: begin
          state <= sma_pkg::ST_IDLE;
          o_sample_valid <= st_go;
          o_left_sample <= g_ch[0].fout;
          o_right_sample <= g_ch[1].fout;
          wr_ptr <= (wr_ptr == 18'(`SMA_COARSE_MAX)) ? 18'h00000 : wr_ptr + 18'h00001;
          fine_ptr <= fine_ptr + 9'h001;
          if (fill != 18'(`SMA_COARSE_DEPTH)) begin
            fill <= fill + 18'h00001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) begin
      rd_mux = {28'h0000000, dc_null_mode, rate_sel};
    end else if (sel_tcorner) begin
      rd_mux = {16'h0000, independent_treble_corner};
    end else if (sel_ltreb) begin
      rd_mux = {16'h0000, left_treble_gain};
    end else if (sel_rtreb) begin
      rd_mux = {16'h0000, right_treble_gain};
    end else if (sel_bcorner) begin
      rd_mux = {16'h0000, bass_corner};
    end else if (sel_xfeed) begin
      rd_mux = {16'h0000, spatial_crossfeed_amount};
    end else if (sel_sdly) begin
      rd_mux = {23'h000000, stereo_coarse_delay};
    end else if (sel_left_coarse_delay) begin
      rd_mux = {23'h000000, left_coarse_delay};
    end else if (sel_right_coarse_delay) begin
      rd_mux = {23'h000000, right_coarse_delay};
    end else if (sel_lfine) begin
      rd_mux = {23'h000000, left_fine_delay};
    end else if (sel_rfine) begin
      rd_mux = {23'h000000, right_fine_delay};
    end else if (sel_fb) begin
      rd_mux = feedback_gains;
    end else if (i_avs_address == `SMA_REG_LEFT_DC) begin
      rd_mux = {24'h000000, g_ch[0].corr_pct[7:0]};
    end else if (i_avs_address == `SMA_REG_RIGHT_DC) begin
      rd_mux = {24'h000000, g_ch[1].corr_pct[7:0]};
    end else if (sel_binaural_boost_setting) begin
      rd_mux = {28'h0000000, binaural_boost_setting_set};
    end else if (i_avs_address == `SMA_REG_LEFT_FTIME) begin
      rd_mux = 32'(left_fine_delay * smp_ns);
    end else if (i_avs_address == `SMA_REG_RIGHT_FTIME) begin
      rd_mux = 32'(right_fine_delay * smp_ns);
    end else if (i_avs_address == `SMA_REG_STATUS) begin
      rd_mux = {30'h00000000, fill == 18'(`SMA_COARSE_DEPTH), o_busy};
    end
  end
endmodule
`default_nettype wire

// ### dv/sma_stereo_adjust_properties.sv
// port-level assertions for the stereo mastering adjust block
`timescale 1ns/100ps
`default_nettype none
module sma_stereo_adjust_props (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // register bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // audio frames
  input wire logic i_sample_valid,
  input wire logic o_sample_valid,
  input wire logic signed [23:0] o_left_sample,
  input wire logic signed [23:0] o_right_sample,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  wire logic req;
  assign req = i_avs_read | i_avs_write;
  a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest high without request");
  a_rdata_hold: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved outside a read");
  a_frame_span: assert property (
    i_sample_valid && !o_busy |=> o_busy [*7] ##1 (!o_busy && o_sample_valid))
    else $error("frame not processed in eight cycles");
  a_valid_end: assert property ($fell(o_busy) |-> o_sample_valid)
    else $error("busy dropped without output frame");
  a_valid_pulse: assert property (o_sample_valid |=> !o_sample_valid)
    else $error("output valid longer than one cycle");
  a_out_hold: assert property (
    !o_sample_valid |-> $stable(o_left_sample) && $stable(o_right_sample))
    else $error("output samples moved between frames");
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
  c_frame: cover property (o_sample_valid);
  c_refused: cover property (i_sample_valid && o_busy);
endmodule
bind sma_stereo_adjust sma_stereo_adjust_props sma_stereo_adjust_props_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_sample_valid(i_sample_valid),
  .o_sample_valid(o_sample_valid), .o_left_sample(o_left_sample),
  .o_right_sample(o_right_sample), .o_busy(o_busy));
`default_nettype wire

// ### dv/sma_audio_partner.sv
// far-side audio source and sink model
`timescale 1ns/100ps
`default_nettype none
module sma_audio_partner (
  // clock
  input wire logic i_sys_clk,
  // frames from the block
  input wire logic i_out_valid,
  input wire logic signed [23:0] i_out_left,
  input wire logic signed [23:0] i_out_right,
  // frames to the block
  output logic o_valid,
  output logic signed [23:0] o_left,
  output logic signed [23:0] o_right
);
  int n_out = 0;
  logic signed [23:0] last_l = 24'sh0;
  logic signed [23:0] last_r = 24'sh0;
  initial begin
    o_valid = 1'b0;
    o_left = 24'sh0;
    o_right = 24'sh0;
  end
  always @(posedge i_sys_clk) begin
    if (i_out_valid) begin
      n_out <= n_out + 1;
      last_l <= i_out_left;
      last_r <= i_out_right;
    end
  end
  // one stereo frame, then the gap; stale lines show inverted data
  task automatic send(input logic signed [23:0] l, input logic signed [23:0] r, input int gap);
    o_valid <= 1'b1;
    o_left <= l;
    o_right <= r;
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    o_left <= ~l;
    o_right <= ~r;
    repeat (gap) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_sma_stereo_adjust.sv
// self-checking bench for the stereo mastering adjust block
`include "sma_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_sma_stereo_adjust;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;
    logic [31:0] mk;} sma_rrow_type;
  typedef struct {logic [15:0] xf; logic [3:0] sh; logic [3:0] ct; logic [15:0] tr;
    logic signed [23:0] il; logic signed [23:0] ir; logic signed [23:0] el;
    logic signed [23:0] er;} sma_frow_type;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic [31:0] rd;
  logic o_avs_waitrequest, i_sample_valid, o_sample_valid, o_busy;
  logic signed [23:0] i_left_sample, i_right_sample, o_left_sample, o_right_sample;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int k, first_l, first_r, cnt0;
  logic [7:0] za[6] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  sma_rrow_type rr[12] = '{
    '{8'h00, 32'h1, 8'h00, 32'h1, 32'hF},
    '{8'h24, 32'h1F4, 8'h3C, 32'h1F4 * 32'h5894, 32'hFFFFFFFF},
    '{8'h00, 32'h2, 8'h00, 32'h2, 32'hF},
    '{8'h28, 32'h1, 8'h40, 32'h7A12, 32'hFFFFFFFF},
    '{8'h00, 32'h8, 8'h00, 32'h8, 32'hF},
    '{8'h24, 32'h2, 8'h3C, 32'hA2C2, 32'hFFFFFFFF},
    '{8'h2C, 32'h639D639D, 8'h2C, 32'h639D639D, 32'hFFFFFFFF},
    '{8'h38, 32'hF, 8'h38, 32'hA, 32'hF},
    '{8'h30, 32'h14, 8'h30, 32'h13, 32'hFF},
    '{8'h30, 32'h32, 8'h30, 32'h31, 32'hFF},
    '{8'h34, 32'hFFFFFFCE, 8'h34, 32'hCE, 32'hFF},
    '{8'h80, 32'h1234, 8'h80, 32'h0, 32'hFFFFFFFF}};
  sma_frow_type fr[7] = '{
    '{16'h0, 4'h0, 4'h4, 16'h4000, 24'sh0, 24'sh0, 24'shC00004, 24'sh3FFFFC},
    '{16'h4000, 4'h0, 4'h0, 16'h4000, 24'sh100000, 24'sh100000, 24'sh0, 24'sh0},
    '{16'h4000, 4'h0, 4'h0, 16'h4000, 24'sh100000, 24'shF00000, 24'sh200000,
      24'shE00000},
    '{16'hC000, 4'h0, 4'h0, 16'h4000, 24'sh100000, 24'sh100000, 24'sh200000,
      24'sh200000},
    '{16'h0, 4'hA, 4'h0, 16'h4000, 24'sh100000, 24'sh100000, 24'sh100000, 24'sh100000},
    '{16'h0, 4'hA, 4'h0, 16'h0, 24'sh100000, 24'sh100000, 24'sh100000, 24'sh100000},
    '{16'h0, 4'h0, 4'h0, 16'h4000, 24'sh100000, 24'shF00000, 24'sh100000,
      24'shF00000}};
  always #2 i_sys_clk = ~i_sys_clk;
  sma_stereo_adjust sma_stereo_adjust_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_sample_valid(i_sample_valid), .i_left_sample(i_left_sample),
    .i_right_sample(i_right_sample), .o_sample_valid(o_sample_valid),
    .o_left_sample(o_left_sample), .o_right_sample(o_right_sample), .o_busy(o_busy));
  sma_audio_partner sma_audio_partner_i (.i_sys_clk(i_sys_clk), .i_out_valid(o_sample_valid),
    .i_out_left(o_left_sample), .i_out_right(o_right_sample), .o_valid(i_sample_valid),
    .o_left(i_left_sample), .o_right(i_right_sample));
  // ----------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic signed [23:0] got, input logic signed [23:0] exp);
    logic signed [24:0] d;
    d = got - exp;
    tests_run++;
    if ((^got === 1'bx) || d > 25'sh40 || d < -25'sh40) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    foreach (rr[j]) begin
      bus(1'b1, rr[j].wa, rr[j].wd);
      bus(1'b0, rr[j].ra, 32'h0);
      cmp(rd & rr[j].mk, rr[j].ex);
    end
    foreach (za[j]) bus(1'b1, za[j], 32'h0);
    bus(1'b1, 8'h10, 32'hFFFF);
    bus(1'b1, 8'h04, 32'hFFFF);
    foreach (fr[j]) begin
      bus(1'b1, 8'h14, {16'h0, fr[j].xf});
      bus(1'b1, 8'h38, {28'h0, fr[j].sh});
      bus(1'b1, 8'h00, {28'h0, fr[j].ct});
      bus(1'b1, 8'h08, {16'h0, fr[j].tr});
      bus(1'b1, 8'h0C, {16'h0, fr[j].tr});
      repeat (40) sma_audio_partner_i.send(fr[j].il, fr[j].ir, 10);
      near(sma_audio_partner_i.last_l, fr[j].el);
      near(sma_audio_partner_i.last_r, fr[j].er);
    end
    // a frame offered while busy is dropped
    cnt0 = sma_audio_partner_i.n_out;
    sma_audio_partner_i.send(24'sh123456, 24'sh0, 1);
    sma_audio_partner_i.send(24'sh0, 24'sh0, 12);
    cmp(32'(sma_audio_partner_i.n_out - cnt0), 32'h1);
    near(sma_audio_partner_i.last_l, 24'sh123456);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b1, 8'h1C, 32'h1);
    bus(1'b1, 8'h24, 32'h3);
    first_l = 0;
    first_r = 0;
    for (k = 0; k < 2000; k++) begin
      sma_audio_partner_i.send(k == 1000 ? 24'sh100000 : 24'sh0,
                               k == 1000 ? 24'sh100000 : 24'sh0, 10);
      if (k >= 1000 && first_l == 0 && sma_audio_partner_i.last_l > 24'sh80000) first_l = k;
      if (k >= 1000 && first_r == 0 && sma_audio_partner_i.last_r > 24'sh80000) first_r = k;
    end
    cmp(32'(first_l), 32'(1000 + 963));
    cmp(32'(first_r), 32'(1000 + 480));
    i_resetn <= 1'b0;
    @(posedge i_sys_clk);
    cmp({29'h0, o_busy, o_sample_valid, o_avs_waitrequest}, 32'h0);
    cmp(o_avs_readdata, 32'h0);
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    cmp(rd, {16'h0, `SMA_RST_COEF});
    complete_run();
  end
endmodule
`default_nettype wire
